//--- rtl/cell_protect_pkg.sv
// Package: constants and types for the two-cell protection state machine
package cell_protect_pkg;

    // System clock period in picoseconds (100 MHz)
    localparam int unsigned SYS_CLK_PERIOD_PS = 10000;
    // Slow internal tick period in picoseconds (about 7.5 kHz)
    localparam int unsigned SLOW_TICK_PERIOD_PS = 133333333;
    // System cycles per slow tick
    localparam int unsigned SLOW_TICK_CYCLES = SLOW_TICK_PERIOD_PS / SYS_CLK_PERIOD_PS;

    // Overvoltage qualification, microseconds: least, typical, longest
    localparam int unsigned HIGH_DLY_MIN_US = 600;
    localparam int unsigned HIGH_DLY_TYP_US = 2000;
    localparam int unsigned HIGH_DLY_MAX_US = 5000;
    // Undervoltage qualification, microseconds: least, typical, longest
    localparam int unsigned LOW_DLY_MIN_US = 300;
    localparam int unsigned LOW_DLY_TYP_US = 1000;
    localparam int unsigned LOW_DLY_MAX_US = 3500;

    // Slow ticks for the typical delays (7.5 ticks per ms)
    localparam int unsigned HIGH_DLY_TICKS = (HIGH_DLY_TYP_US * 15) / 2000;
    localparam int unsigned LOW_DLY_TICKS = (LOW_DLY_TYP_US * 15) / 2000;

    // Width of the slow tick divider and the qualification counters
    localparam int unsigned DIV_W = 24;
    localparam int unsigned QUAL_W = 8;

    // Protection states
    typedef enum logic [2:0] {
        ST_DISABLED,
        ST_NORMAL,
        ST_HIGH,
        ST_LOW,
        ST_HIGH_LOW
    } prot_state_t;

    // Pass switch commands
    typedef enum logic [1:0] {
        SW_OFF,
        SW_FULL_ON,
        SW_DISCHARGE_ONLY,
        SW_CHARGE_ONLY
    } switch_mode_t;

endpackage

//--- rtl/two_cell_protection_fsm.sv
// Protection state machine for a two-cell pack with qualified fault detection
//
// How it works
// - Overvoltage asserted after 2.0 ms qualification
// - Undervoltage asserted after 0.93 ms (7 slow ticks) qualification
// - Enable held low keeps switch off
// - Normal state: switch fully on
// - Low-charge warning high below 3.0 V
// - Warning returns low on undervoltage entry
// - High-cell flag low while overvoltage bit
// - Overvoltage bit opens switch against charging
// - Low-cell flag low while undervoltage bit
// - Undervoltage bit opens switch against discharging
// - Overcharged state passes discharge current only
// - Over-discharged state passes charge current only
// - Leave overvoltage only below recovery on both
// - Undervoltage without overvoltage sleeps until both cells above 3 V
// - One high, one low: switch off, both flags
module two_cell_protection_fsm
    import cell_protect_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Chip enable pin, low holds the pack off
    input wire logic i_chip_enable,
    // Per-cell comparator results, index 0 lower cell, 1 upper cell
    input wire logic [1:0] i_cell_over,
    input wire logic [1:0] i_cell_over_recovered,
    input wire logic [1:0] i_cell_under,
    input wire logic [1:0] i_cell_below_warn,
    // Status outputs
    output logic o_high_cell_flag_n,
    output logic o_low_cell_flag_n,
    output logic o_low_charge_warning,
    // Pass switch command and sleep indication
    output switch_mode_t o_switch_mode,
    output logic o_sleep
);

    // Raw asynchronous inputs gathered for synchronising
    localparam int unsigned RAW_W = 9;

    // Whole module state
    typedef struct packed {
        logic [RAW_W-1:0] sync1;    // First synchroniser stage
        logic [RAW_W-1:0] sync2;    // Second synchroniser stage
        logic [DIV_W-1:0] div;      // Slow tick divider
        logic [QUAL_W-1:0] high_cnt; // Overvoltage qualification count
        logic [QUAL_W-1:0] low_cnt;  // Undervoltage qualification count
        prot_state_t state;         // Protection state
        logic warn;                 // Low-charge warning
        switch_mode_t sw;           // Pass switch command
    } core_t;

    core_t cur;
    core_t nxt;

    // Synchronised views of the inputs
    logic en_s;
    logic [1:0] over_s;
    logic [1:0] recov_s;
    logic [1:0] under_s;
    logic [1:0] warn_s;
    logic tick;
    logic high_q;
    logic low_q;

    // Counter step: restart when released, advance on tick, saturate at limit
    function automatic logic [QUAL_W-1:0] qual_step(
        input logic active,
        input logic tk,
        input logic [QUAL_W-1:0] cnt,
        input logic [QUAL_W-1:0] limit
    );
        logic [QUAL_W-1:0] r;
        r = cnt;
        if (!active)
        begin
            r = '0;
        end
        else if (tk && cnt < limit)
        begin
            r = cnt + 8'h01;
        end
        return r;
    endfunction

    // Switch command for a protection state
    function automatic switch_mode_t sw_for(input prot_state_t st);
        switch_mode_t r;
        case (st)
            ST_NORMAL: r = SW_FULL_ON;
            ST_HIGH: r = SW_DISCHARGE_ONLY;
            ST_LOW: r = SW_CHARGE_ONLY;
            ST_HIGH_LOW: r = SW_OFF;
            default: r = SW_OFF;
        endcase
        return r;
    endfunction

    // Unpack synchronised inputs; only the second stage is read
    always_comb
    begin
        en_s = cur.sync2[8];
        over_s = cur.sync2[7:6];
        recov_s = cur.sync2[5:4];
        under_s = cur.sync2[3:2];
        warn_s = cur.sync2[1:0];
        tick = (cur.div == DIV_W'(SLOW_TICK_CYCLES - 1));
        high_q = (cur.high_cnt == QUAL_W'(HIGH_DLY_TICKS));
        low_q = (cur.low_cnt == QUAL_W'(LOW_DLY_TICKS));
    end

    // Next-state logic
    always_comb
    begin
        nxt = cur;
        nxt.sync1 = {i_chip_enable, i_cell_over, i_cell_over_recovered,
                     i_cell_under, i_cell_below_warn};
        nxt.sync2 = cur.sync1;
        // Slow tick divider
        if (tick)
        begin
            nxt.div = '0;
        end
        else
        begin
            nxt.div = cur.div + 24'h000001;
        end
        // Qualification counts restart whenever the comparator drops
        nxt.high_cnt = qual_step(|over_s, tick, cur.high_cnt,
                                 QUAL_W'(HIGH_DLY_TICKS));
        nxt.low_cnt = qual_step(|under_s, tick, cur.low_cnt,
                                QUAL_W'(LOW_DLY_TICKS));
        if (!en_s)
        begin
            // Enable low resets the state, both qualification counts and the warning
            nxt.state = ST_DISABLED;
            nxt.high_cnt = '0;
            nxt.low_cnt = '0;
            nxt.warn = 1'b0;
        end
        else
        begin
            case (cur.state)
                ST_DISABLED:
                begin
                    nxt.state = ST_NORMAL;
                end
                ST_NORMAL:
                begin
                    if (high_q && low_q)
                    begin
                        nxt.state = ST_HIGH_LOW;
                    end
                    else if (high_q)
                    begin
                        nxt.state = ST_HIGH;
                    end
                    else if (low_q)
                    begin
                        nxt.state = ST_LOW;
                    end
                end
                ST_HIGH:
                begin
                    if (low_q)
                    begin
                        nxt.state = ST_HIGH_LOW;
                    end
                    else if (&recov_s)
                    begin
                        nxt.state = ST_NORMAL;
                    end
                end
                ST_LOW:
                begin
                    if (high_q)
                    begin
                        nxt.state = ST_HIGH_LOW;
                    end
                    else if (warn_s == 2'b00)
                    begin
                        nxt.state = ST_NORMAL;
                    end
                end
                ST_HIGH_LOW:
                begin
                    // Leave only when one of the two faults clears
                    if (&recov_s)
                    begin
                        nxt.state = ST_LOW;
                    end
                    else if (warn_s == 2'b00)
                    begin
                        nxt.state = ST_HIGH;
                    end
                end
                default:
                begin
                    nxt.state = ST_DISABLED;
                end
            endcase
            // Warning follows the 3 V comparators outside undervoltage
            if (nxt.state == ST_LOW || nxt.state == ST_HIGH_LOW)
            begin
                nxt.warn = 1'b0;
            end
            else
            begin
                nxt.warn = |warn_s;
            end
        end
        nxt.sw = sw_for(nxt.state);
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cur <= '{sync1: '0, sync2: '0, div: '0, high_cnt: '0, low_cnt: '0,
                     state: ST_DISABLED, warn: 1'b0, sw: SW_OFF};
        end
        else
        begin
            cur <= nxt;
        end
    end

    // Registered outputs
    always_comb
    begin
        o_high_cell_flag_n = !(cur.state == ST_HIGH || cur.state == ST_HIGH_LOW);
        o_low_cell_flag_n = !(cur.state == ST_LOW || cur.state == ST_HIGH_LOW);
        o_low_charge_warning = cur.warn;
        o_switch_mode = cur.sw;
        o_sleep = (cur.state == ST_LOW);
    end

endmodule

//--- testbench/cell_stack_model.sv
// Cell stack model: turns two cell voltages into comparator results
module cell_stack_model
(
    // Cell voltages in millivolts, index 0 lower cell
    input wire logic [15:0] i_mv [2],
    // Comparator results seen by the block
    output logic [1:0] o_over,
    output logic [1:0] o_recovered,
    output logic [1:0] o_under,
    output logic [1:0] o_warn
);
    timeunit 1ns;
    timeprecision 1ps;

    // Threshold comparisons, one bit per cell in each output pair
    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            o_over[k] = i_mv[k] > 16'h109a; // Above 4250 mV
            o_recovered[k] = i_mv[k] < 16'h0ea6; // Below 3750 mV
            o_under[k] = i_mv[k] < 16'h09c4; // Below 2500 mV
            o_warn[k] = i_mv[k] < 16'h0bb8; // Below 3000 mV
        end
    end
endmodule

//--- testbench/two_cell_protection_fsm_properties.sv
// Checker: port relations of the protection state machine
module two_cell_protection_fsm_checker
    import cell_protect_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_chip_enable,
    input wire logic [1:0] i_cell_over,
    input wire logic [1:0] i_cell_under,
    input wire logic o_high_cell_flag_n,
    input wire logic o_low_cell_flag_n,
    input wire logic o_low_charge_warning,
    input wire switch_mode_t o_switch_mode,
    input wire logic o_sleep
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    // Cycles each fault input has been held, saturating
    logic [16:0] over_cnt;
    logic [16:0] under_cnt;

    // Hold counters for the qualification bounds
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            over_cnt <= '0;
            under_cnt <= '0;
        end
        else
        begin
            over_cnt <= (|i_cell_over) ? over_cnt + 17'(over_cnt != '1) : '0;
            under_cnt <= (|i_cell_under) ? under_cnt + 17'(under_cnt != '1) : '0;
        end
    end

    property p_full_on; o_switch_mode == SW_FULL_ON |-> o_high_cell_flag_n && o_low_cell_flag_n; endproperty
    a_full_on: assert property (p_full_on) else $error("full on outside normal");
    property p_high; !o_high_cell_flag_n && o_low_cell_flag_n |-> o_switch_mode == SW_DISCHARGE_ONLY; endproperty
    a_high: assert property (p_high) else $error("high state switch wrong");
    property p_low; o_high_cell_flag_n && !o_low_cell_flag_n |-> o_switch_mode == SW_CHARGE_ONLY; endproperty
    a_low: assert property (p_low) else $error("low state switch wrong");
    property p_both; !o_high_cell_flag_n && !o_low_cell_flag_n |-> o_switch_mode == SW_OFF; endproperty
    a_both: assert property (p_both) else $error("double fault switch not off");
    property p_sleep; o_sleep |-> !o_low_cell_flag_n && o_high_cell_flag_n; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep outside low state");
    property p_warn; !o_low_cell_flag_n |-> !o_low_charge_warning; endproperty
    a_warn: assert property (p_warn) else $error("warning high in low state");
    property p_enable; !i_chip_enable [*5] |-> o_switch_mode == SW_OFF; endproperty
    a_enable: assert property (p_enable) else $error("switch on while disabled");
    property p_over_qual;
        $fell(o_high_cell_flag_n) |-> over_cnt >= 17'(HIGH_DLY_MIN_US * 1000000 / SYS_CLK_PERIOD_PS);
    endproperty
    a_over_qual: assert property (p_over_qual) else $error("overvoltage too early");
    property p_under_qual;
        $fell(o_low_cell_flag_n) |-> under_cnt >= 17'(LOW_DLY_MIN_US * 1000000 / SYS_CLK_PERIOD_PS);
    endproperty
    a_under_qual: assert property (p_under_qual) else $error("undervoltage too early");
    c_full_on: cover property (o_switch_mode == SW_FULL_ON);
    c_warn: cover property ($rose(o_low_charge_warning));
    c_sleep: cover property ($rose(o_sleep));
endmodule

bind two_cell_protection_fsm two_cell_protection_fsm_checker two_cell_protection_fsm_checker_i (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_chip_enable(i_chip_enable),
    .i_cell_over(i_cell_over), .i_cell_under(i_cell_under),
    .o_high_cell_flag_n(o_high_cell_flag_n), .o_low_cell_flag_n(o_low_cell_flag_n),
    .o_low_charge_warning(o_low_charge_warning), .o_switch_mode(o_switch_mode),
    .o_sleep(o_sleep));

//--- testbench/two_cell_protection_fsm_tb_top.sv
// Testbench: walks the block through enable, warning and undervoltage
module two_cell_protection_fsm_tb_top import cell_protect_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 0;
    logic i_reset_n = 0;
    logic i_chip_enable = 0;
    logic [15:0] mv [2] = '{16'h0e10, 16'h0e10};
    logic [1:0] ov, rc, un, wn;
    logic hf_n, lf_n, warn, slp;
    switch_mode_t sw;
    int err_count = 0;
    int tests_run = 0;
    int n;
    // System clock cycles per microsecond
    localparam int unsigned CYC_PER_US = 1000000 / SYS_CLK_PERIOD_PS;

    // Clock at 100 MHz
    always #5 i_mclk = ~i_mclk;

    cell_stack_model cell_stack_model_i (.i_mv(mv), .o_over(ov), .o_recovered(rc),
        .o_under(un), .o_warn(wn));
    two_cell_protection_fsm two_cell_protection_fsm_i (.i_mclk(i_mclk),
        .i_reset_n(i_reset_n), .i_chip_enable(i_chip_enable), .i_cell_over(ov),
        .i_cell_over_recovered(rc), .i_cell_under(un), .i_cell_below_warn(wn),
        .o_high_cell_flag_n(hf_n), .o_low_cell_flag_n(lf_n),
        .o_low_charge_warning(warn), .o_switch_mode(sw), .o_sleep(slp));

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Print counts and verdict, then end
    task automatic stop_test();
        $display("checks=%0d errors=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Wait a number of falling edges
    task automatic idle(input int c);
        repeat (c) @(negedge i_mclk);
    endtask

    // Watchdog: whole sequence takes under 100k cycles, allow 110k
    initial
    begin
        #(1100000);
        err_count++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        idle(17);
        i_reset_n = 1; // Enable stays low as during assembly
        idle(10);
        chk(sw, SW_OFF);
        i_chip_enable = 1;
        idle(6);
        chk(sw, SW_FULL_ON);
        chk({hf_n, lf_n}, 2'b11);
        mv[1] = 16'h0b54; // 2900 mV
        idle(6);
        chk(warn, 1'b1);
        mv[0] = 16'h10cc; // 4300 mV
        idle(5000);
        mv[0] = 16'h0e10; // 3600 mV
        idle(5);
        chk(hf_n, 1'b1);
        mv[0] = 16'h0960; // 2400 mV
        n = 0;
        while (lf_n !== 1'b0 && n < 120000)
        begin
            idle(1);
            n++;
        end
        chk(n >= LOW_DLY_MIN_US * CYC_PER_US && n <= LOW_DLY_MAX_US * CYC_PER_US, 1'b1);
        chk(n > (LOW_DLY_TICKS - 1) * SLOW_TICK_CYCLES &&
            n <= LOW_DLY_TICKS * SLOW_TICK_CYCLES + 5, 1'b1);
        chk(sw, SW_CHARGE_ONLY);
        chk(warn, 1'b0);
        chk(slp, 1'b1);
        mv[0] = 16'h0c1c; // 3100 mV
        mv[1] = 16'h0c1c;
        idle(6);
        chk({sw, slp}, {SW_FULL_ON, 1'b0});
        i_chip_enable = 0;
        idle(6);
        chk(sw, SW_OFF);
        i_chip_enable = 1;
        idle(6);
        chk({sw, hf_n, lf_n, warn}, {SW_FULL_ON, 3'h6});
        stop_test();
    end
endmodule
